// ### hw/dap_pkg.sv
// package for the dual-channel sample processing block
// assumes one 20 MHz clock domain and an APB register bus
package dap_pkg;

    localparam int          DIFF_W    = 24;
    localparam int          CM_W      = 8;
    localparam int          GAIN_W    = 16;
    localparam int          AVG_MAX_N = 16;
    localparam int          ACC_W     = DIFF_W + AVG_MAX_N;

    // conversion time
    localparam int          CONV_TIME_NS = 300;
    localparam int          CLK_PERIOD_NS = 50;
    localparam int          CONV_CYCLES  = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // register byte offsets
    localparam logic [11:0] REG_MODE    = 12'h000;
    localparam logic [11:0] REG_OFS0    = 12'h004;
    localparam logic [11:0] REG_OFS1    = 12'h008;
    localparam logic [11:0] REG_GAIN0   = 12'h00c;
    localparam logic [11:0] REG_GAIN1   = 12'h010;
    localparam logic [11:0] REG_DATA0   = 12'h014;
    localparam logic [11:0] REG_DATA1   = 12'h018;
    localparam logic [11:0] REG_STATUS  = 12'h01c;

    // mode register fields
    localparam int          FMT_LSB     = 0;
    localparam int          AVGN_LSB    = 8;

    // reset values
    localparam logic [2:0]  FMT_RST     = 3'h0;
    localparam logic [4:0]  AVGN_RST    = 5'h00;
    localparam logic [23:0] OFS_RST     = 24'h000000;
    localparam logic [15:0] GAIN_RST    = 16'h8000;

    // output formats
    localparam logic [2:0]  FMT_DIFF24  = 3'h0;
    localparam logic [2:0]  FMT_D16CM   = 3'h1;
    localparam logic [2:0]  FMT_D24CM   = 3'h2;
    localparam logic [2:0]  FMT_AVG     = 3'h3;

    localparam logic [23:0] SAT_POS     = 24'h7fffff;
    localparam logic [23:0] SAT_NEG     = 24'h800000;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_CONV = 2'b10
    } dap_state_e;

    // raw conversion result from the analog core
    typedef struct packed {
        logic [23:0] diff;
        logic [7:0]  cm;
        logic        sat;
    } dap_raw_s;

    typedef struct packed {
        logic [2:0]  fmt;
        logic [4:0]  avgN;
    } dap_mode_s;

endpackage

// ### hw/dap_sample_proc.sv
// dual-channel conversion sequencing and per-channel sample processing
// assumes the analog core presents clamped raw codes, valid at busy fall
//
// The APB register port and the address map were decided locally.
`timescale 1ns/1ns
`default_nettype none

module dap_sample_proc
    import dap_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        convStartPin,
    output logic             busy,
    input  wire dap_raw_s    rawCh0,
    input  wire dap_raw_s    rawCh1,
    output logic [31:0]      dataCh0,
    output logic [31:0]      dataCh1,
    output logic             dataValid,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr
);

    ////////////////////////////////////////////////////////////////////////////
    // start pin sync and sequencing

    logic                    startS1_r;
    logic                    startS2_r;
    logic                    startS3_r;
    logic                    startEdge;
    dap_state_e              state_r;
    logic [7:0]              convCnt_r;
    logic                    convDone;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            startS1_r <= 1'b0;
            startS2_r <= 1'b0;
            startS3_r <= 1'b0;
        end else begin
            startS1_r <= convStartPin;
            startS2_r <= startS1_r;
            startS3_r <= startS2_r;
        end
    end

    assign startEdge = startS2_r && !startS3_r;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r   <= ST_IDLE;
            convCnt_r <= 8'h00;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (startEdge) begin
                        state_r   <= ST_CONV;
                        convCnt_r <= 8'(CONV_CYCLES - 1);
                    end
                end
                ST_CONV: begin
                    // start edges during conversion are ignored
                    if (convCnt_r == 8'h00) begin
                        state_r <= ST_IDLE;
                    end else begin
                        convCnt_r <= convCnt_r - 8'h01;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    assign convDone = (state_r == ST_CONV) && (convCnt_r == 8'h00);
    assign busy     = (state_r == ST_CONV);

    ////////////////////////////////////////////////////////////////////////////
    // registers

    dap_mode_s               mode_r;
    logic [23:0]             ofs_r  [2];
    logic [15:0]             gain_r [2];
    logic [31:0]             outW_r [2];
    logic                    avgActive;
    logic                    wrEn;
    logic                    addrOk;

    assign wrEn = psel && penable && pwrite;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_r.fmt  <= FMT_RST;
            mode_r.avgN <= AVGN_RST;
            ofs_r[0]    <= OFS_RST;
            ofs_r[1]    <= OFS_RST;
            gain_r[0]   <= GAIN_RST;
            gain_r[1]   <= GAIN_RST;
        end else if (wrEn) begin
            case (paddr)
                REG_MODE: begin
                    mode_r.fmt  <= pwdata[FMT_LSB +: 3];
                    mode_r.avgN <= pwdata[AVGN_LSB +: 5];
                end
                REG_OFS0:  ofs_r[0]  <= pwdata[23:0];
                REG_OFS1:  ofs_r[1]  <= pwdata[23:0];
                REG_GAIN0: gain_r[0] <= pwdata[15:0];
                REG_GAIN1: gain_r[1] <= pwdata[15:0];
                default: begin
                end
            endcase
        end
    end

    // single-cycle access phase; no wait states
    assign pready = 1'b1;

    always_comb begin
        addrOk = 1'b1;
        prdata = 32'h00000000;
        case (paddr)
            REG_MODE:   prdata = {19'h00000, mode_r.avgN, 5'h00, mode_r.fmt};
            REG_OFS0:   prdata = {8'h00, ofs_r[0]};
            REG_OFS1:   prdata = {8'h00, ofs_r[1]};
            REG_GAIN0:  prdata = {16'h0000, gain_r[0]};
            REG_GAIN1:  prdata = {16'h0000, gain_r[1]};
            REG_DATA0:  prdata = outW_r[0];
            REG_DATA1:  prdata = outW_r[1];
            REG_STATUS: prdata = {31'h00000000, busy};
            default:    addrOk = 1'b0;
        endcase
    end

    assign pslverr = psel && penable && !addrOk;

    // exponent above 16 is treated as no averaging
    assign avgActive = (mode_r.fmt == FMT_AVG) && (mode_r.avgN != 5'h00)
                     && (mode_r.avgN <= 5'(AVG_MAX_N));

    ////////////////////////////////////////////////////////////////////////////
    // shared block counter, one per both channels since format is common

    logic [15:0]             blkCnt_r;
    logic                    blkLast;
    logic [15:0]             blkMask;

    assign blkMask = avgActive ? 16'((17'h00001 << mode_r.avgN) - 17'h00001) : 16'h0000;
    assign blkLast = (blkCnt_r == blkMask);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            blkCnt_r <= 16'h0000;
        end else if (!avgActive) begin
            blkCnt_r <= 16'h0000;
        end else if (convDone) begin
            blkCnt_r <= blkLast ? 16'h0000 : blkCnt_r + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dataValid <= 1'b0;
        end else begin
            dataValid <= convDone && blkLast;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-channel datapath

    dap_raw_s                rawIn [2];
    assign rawIn[0] = rawCh0;
    assign rawIn[1] = rawCh1;

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : gChan
            logic signed [24:0] sumOfs;
            logic signed [41:0] prod;
            logic signed [26:0] scaled;
            logic        [23:0] satD;
            logic               satHit;
            logic signed [ACC_W-1:0] acc_r;
            logic signed [ACC_W-1:0] accNext;
            logic               orFlag_r;
            logic        [29:0] avgVal;

            // raw code already clamped by the core, flagged by sat
            assign sumOfs = 25'(signed'(rawIn[ch].diff)) + 25'(signed'(ofs_r[ch]));
            assign prod   = 42'(sumOfs) * 42'(signed'({1'b0, gain_r[ch]}));
            assign scaled = 27'(prod >>> 15);

            always_comb begin
                satHit = 1'b0;
                satD   = scaled[23:0];
                if (scaled > 27'sd8388607) begin
                    satD   = SAT_POS;
                    satHit = 1'b1;
                end else if (scaled < -27'sd8388608) begin
                    satD   = SAT_NEG;
                    satHit = 1'b1;
                end
            end

            assign accNext = ((blkCnt_r == 16'h0000) ? '0 : acc_r)
                           + ACC_W'(signed'(satD));

            // 30-bit average: sum shifted so the top 24 bits track the input
            always_comb begin
                avgVal = 30'(accNext >>> (mode_r.avgN - 5'd6));
                if (mode_r.avgN < 5'd6) begin
                    avgVal = 30'(accNext <<< (5'd6 - mode_r.avgN));
                end
            end

            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    acc_r    <= '0;
                    orFlag_r <= 1'b0;
                end else if (convDone) begin
                    acc_r    <= accNext;
                    orFlag_r <= (blkCnt_r != 16'h0000 && orFlag_r)
                              || satHit || rawIn[ch].sat;
                end
            end

            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    outW_r[ch] <= 32'h00000000;
                end else if (convDone) begin
                    // loaded at busy fall with the latest conversion, or with the block average at block end when averaging; mid-block only bit 31 is cleared
                    case (mode_r.fmt)
                        FMT_D16CM: outW_r[ch] <= {8'h00, satD[23:8], rawIn[ch].cm};
                        FMT_D24CM: outW_r[ch] <= {satD, rawIn[ch].cm};
                        FMT_AVG: begin
                            if (avgActive) begin
                                if (blkLast) begin
                                    outW_r[ch] <= {1'b1,
                                        (blkCnt_r != 16'h0000 && orFlag_r)
                                        || satHit || rawIn[ch].sat, avgVal};
                                end else begin
                                    outW_r[ch][31] <= 1'b0;
                                end
                            end else begin
                                outW_r[ch] <= {1'b1, satHit || rawIn[ch].sat, satD, 6'h00};
                            end
                        end
                        default: outW_r[ch] <= {8'h00, satD};
                    endcase
                end
            end
        end
    endgenerate

    assign dataCh0 = outW_r[0];
    assign dataCh1 = outW_r[1];

endmodule

`default_nettype wire

// ### test/dap_host_model.sv
// host-side model that drives the conversion start pin
// assumes one clock; a go pulse from the bench starts a frame
`timescale 1ns/1ns
`default_nettype none
module dap_host_model (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic go,
    output logic      convStartPin
);
    logic [2:0] holdCnt_r;
    ////////////////////////////////////////////////////////////////
    // wide high level: the pin is synced, a short pulse could be missed
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            holdCnt_r <= 3'h0;
        end else if (go) begin
            holdCnt_r <= 3'h5;
        end else if (holdCnt_r != 3'h0) begin
            holdCnt_r <= holdCnt_r - 3'h1;
        end
    end
    assign convStartPin = (holdCnt_r != 3'h0);
endmodule
`default_nettype wire

// ### test/dap_sva.sv
// port checker for dap_sample_proc
// assumes bind to the design top, one clock domain
`timescale 1ns/1ns
`default_nettype none
module dap_sva (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        convStartPin,
    input wire logic        busy,
    input wire logic [31:0] dataCh0,
    input wire logic [31:0] dataCh1,
    input wire logic        dataValid
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////////
    property p_busyLen; $rose(busy) |-> busy[*6] ##1 !busy; endproperty
    a_busyLen: assert property (p_busyLen) else $error("busy length wrong");
    property p_busyGo; $rose(convStartPin) && !busy |-> ##[1:5] $rose(busy); endproperty
    a_busyGo: assert property (p_busyGo) else $error("start not taken");
    property p_busyCause; $rose(busy) |-> $past(convStartPin); endproperty
    a_busyCause: assert property (p_busyCause) else $error("busy without start");
    property p_validPulse; dataValid |=> !dataValid; endproperty
    a_validPulse: assert property (p_validPulse) else $error("valid too long");
    property p_validIdle; dataValid |-> !busy; endproperty
    a_validIdle: assert property (p_validIdle) else $error("valid while busy");
    property p_validCause; dataValid |-> $past(busy) || $past(busy, 2); endproperty
    a_validCause: assert property (p_validCause) else $error("valid without conv");
    property p_hold0; $changed(dataCh0) |-> $past(busy); endproperty
    a_hold0: assert property (p_hold0) else $error("ch0 data moved");
    property p_hold1; $changed(dataCh1) |-> $past(busy); endproperty
    a_hold1: assert property (p_hold1) else $error("ch1 data moved");
endmodule
bind dap_sample_proc dap_sva i_dap_sva (.clk(clk), .rst_b(rst_b),
    .convStartPin(convStartPin), .busy(busy), .dataCh0(dataCh0),
    .dataCh1(dataCh1), .dataValid(dataValid));
`default_nettype wire

// ### test/tb.sv
// bench for dap_sample_proc: apb, start pin, raw codes
// assumes dap_host_model drives the start pin
`timescale 1ns/1ns
`default_nettype none
module tb
    import dap_pkg::*;
;
    logic        clk, rst_b, go, psel, penable, pwrite, pready, pslverr;
    logic        convStartPin, busy, dataValid, er, v;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, d0, d1, seed;
    dap_raw_s    raw0, raw1;
    logic [23:0] cv [5] = '{24'h0, 24'h1, 24'hffffff, 24'h800001, 24'h7fffff};
    int          errors, compares;
    dap_sample_proc i_dap_sample_proc (.clk(clk), .rst_b(rst_b),
        .convStartPin(convStartPin), .busy(busy), .rawCh0(raw0), .rawCh1(raw1),
        .dataCh0(d0), .dataCh1(d1), .dataValid(dataValid), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    dap_host_model i_dap_host_model (.clk(clk), .rst_b(rst_b), .go(go),
        .convStartPin(convStartPin));
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // offset, gain, then clamp; floor shift as the designer chose
    function automatic logic [23:0] proc(input logic [23:0] c, o, input logic [15:0] g);
        logic signed [43:0] s;
        s = $signed({{20{c[23]}}, c}) + $signed({{20{o[23]}}, o});
        s = (s * $signed({28'h0, g})) >>> 15;
        if (s > 44'sh7fffff) return SAT_POS;
        if (s < -44'sh800000) return SAT_NEG;
        return s[23:0];
    endfunction
    task chk(input string nm, input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task conv(input dap_raw_s a, b);
        int n;
        @(posedge clk);
        raw0 <= a;
        raw1 <= b;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        n = 0;
        do begin @(posedge clk); #1; n++; end while (busy !== 1'b1 && n < 20);
        do begin @(posedge clk); #1; n++; end while (busy !== 1'b0 && n < 40);
        v = dataValid;
        @(posedge clk);
        #1 v = v | dataValid;
        chk("busy", {31'h0, busy}, 32'h0);
    endtask
    task wrap_up;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        wrap_up();
    end
    initial begin
        logic [23:0] c, o, e, f;
        logic [15:0] g;
        {rst_b, go, psel, penable, pwrite, paddr, pwdata} = '0;
        raw0 = '0;
        raw1 = '0;
        seed = 32'h7065;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        apb(1'b0, REG_MODE, 32'h0);
        chk("mode", rd, 32'h0);
        apb(1'b0, REG_OFS1, 32'h0);
        chk("ofs1", rd, 32'h0);
        apb(1'b0, REG_GAIN0, 32'h0);
        chk("gain0", rd, 32'h8000);
        apb(1'b0, 12'h0f0, 32'h0);
        chk("unmapped", {31'h0, er}, 32'h1);
        foreach (cv[i]) begin
            conv(dap_raw_s'{cv[i], 8'h0, 1'b0}, dap_raw_s'{~cv[i], 8'h0, 1'b0});
            chk("code0", d0, {8'h0, cv[i]});
            chk("code1", d1, {8'h0, ~cv[i]});
            chk("valid", {31'h0, v}, 32'h1);
        end
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            c = seed[23:0];
            seed = lfsr(seed);
            o = {{4{seed[31]}}, seed[31:12]};
            g = seed[15:0];
            if (i == 0) begin
                c = 24'h800001;
                o = 24'h800000;
                g = 16'h8000;
            end
            apb(1'b1, REG_OFS0, {8'h0, o});
            apb(1'b1, REG_OFS1, {8'h0, ~o});
            apb(1'b1, REG_GAIN0, {16'h0, g});
            apb(1'b1, REG_GAIN1, {16'h0, ~g});
            conv(dap_raw_s'{c, 8'h5, 1'b0}, dap_raw_s'{~c, 8'h5, 1'b0});
            chk("proc0", d0, {8'h0, proc(c, o, g)});
            chk("proc1", d1, {8'h0, proc(~c, ~o, ~g)});
        end
        e = proc(c, o, g);
        f = proc(~c, ~o, ~g);
        apb(1'b1, REG_MODE, 32'h1);
        conv(dap_raw_s'{c, 8'hff, 1'b0}, dap_raw_s'{~c, 8'hff, 1'b0});
        chk("fmt1", d0, {8'h0, e[23:8], 8'hff});
        chk("fmt1ch1", d1, {8'h0, f[23:8], 8'hff});
        apb(1'b1, REG_MODE, 32'h2);
        conv(dap_raw_s'{c, 8'h00, 1'b0}, dap_raw_s'{~c, 8'h00, 1'b0});
        chk("fmt2", d0, {e, 8'h00});
        apb(1'b1, REG_OFS0, 32'h0);
        apb(1'b1, REG_GAIN0, 32'h8000);
        apb(1'b1, REG_MODE, 32'h203);
        for (int k = 0; k < 8; k++) begin
            conv(dap_raw_s'{c, 8'h11, k == 2}, dap_raw_s'{c, 8'h22, 1'b0});
            chk("blkvalid", {31'h0, v}, {31'h0, k % 4 == 3});
            if (k % 4 == 3) begin
                chk("avg", d0, {1'b1, 1'(k < 4), c, 6'h0});
            end else begin
                chk("sync", {31'h0, d0[31]}, 32'h0);
            end
        end
        apb(1'b1, REG_MODE, 32'h3);
        conv(dap_raw_s'{c, 8'h0, 1'b0}, dap_raw_s'{c, 8'h0, 1'b0});
        chk("n0", d0, {2'b10, c, 6'h0});
        chk("n0valid", {31'h0, v}, 32'h1);
        apb(1'b1, REG_MODE, 32'h1103);
        conv(dap_raw_s'{c, 8'h0, 1'b0}, dap_raw_s'{c, 8'h0, 1'b0});
        chk("n17", d0, {2'b10, c, 6'h0});
        apb(1'b1, REG_MODE, 32'h4);
        conv(dap_raw_s'{c, 8'h0, 1'b0}, dap_raw_s'{c, 8'h0, 1'b0});
        chk("fmt4", d0, {8'h0, c});
        wrap_up();
    end
endmodule
`default_nettype wire
